// *** logic/stp_tap.sv ***
// stp_tap: boundary-scan test access port of a burst sram
// assumes test pins arrive asynchronously and are oversampled by CLK_SYS_I
//
// Overview of operation
// - mode select and data in idle high
// - power-up reset leaves memory undisturbed
// - sample on rising, drive on falling edge
// - instruction selects the data register
// - only one register in the path
// - shift in at msb, out lsb
// - output enabled only in shift states
// - five high mode edges force reset
// - tap reset never touches memory
// - power-up leaves serial output tristated
// - three bit ir, loaded in ir path
// - reset loads identification instruction
// - ir capture loads 01 pattern
// - one bit bypass register
// - bypass cleared when bypass executes
// - new instruction takes effect at update
// - identification value captured in data capture
`timescale 1ns/1ps
module stp_tap
  import stp_pkg::*;
#(
  parameter logic [ID_W-1:0] ID_VALUE = 32'h0000_0001 // arbitrary value
) (
  input  wire logic             CLK_SYS_I,  // system clock
  input  wire logic             SYS_RST_I,  // sync reset, high
  input  wire logic             TCK_I,      // test clock pin
  input  wire logic             TMS_I,      // mode select, pulled up
  input  wire logic             TMS_PRESENT_I, // low when pin floats
  input  wire logic             TDI_I,      // serial in, pulled up
  input  wire logic             TDI_PRESENT_I, // low when pin floats
  input  wire logic [BSR_W-1:0] PINS_I,     // sampled memory pins
  output logic                  TDO_O,      // serial out
  output logic                  TDO_OE_O,   // serial out enable
  output logic [IR_W-1:0]       INSTR_O,    // active instruction
  output logic [BSR_W-1:0]      BSR_UPD_O,  // boundary preload latch
  output logic                  TLR_O       // in reset state
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0]       pin_raw;
  logic [4:0]       s1_reg;
  logic [4:0]       s2_reg;
  logic             tck_d_reg;
  logic             tck_s;
  logic             tms_s;
  logic             tdi_s;
  logic             tck_rise;
  logic             tck_fall;
  logic [BSR_W-1:0] pins_s1_reg;
  logic [BSR_W-1:0] pins_s2_reg;

  // {data present, data, mode present, mode, clock}; presence is a pin too
  assign pin_raw = {TDI_PRESENT_I, TDI_I, TMS_PRESENT_I, TMS_I, TCK_I};

  // two flops per pin; only the second one is read, idle is clock low
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      s1_reg    <= 5'h1E;
      s2_reg    <= 5'h1E;
      tck_d_reg <= 1'b0;
    end
    else
    begin
      s1_reg    <= pin_raw;
      s2_reg    <= s1_reg;
      tck_d_reg <= s2_reg[0];
    end
  end

  // memory pins run on the memory clock; a value moving at capture may
  // land either way, but it never goes metastable inside the chain
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
    end
    else
    begin
      pins_s1_reg <= PINS_I;
      pins_s2_reg <= pins_s1_reg;
    end
  end

  // a floating pin reads high through its pull-up
  assign tck_s = s2_reg[0];
  assign tms_s = s2_reg[1] | ~s2_reg[2];
  assign tdi_s = s2_reg[3] | ~s2_reg[4];

  // a held-low test clock never produces edges
  assign tck_rise = tck_s & ~tck_d_reg;
  assign tck_fall = ~tck_s & tck_d_reg;

  // ****************************************
  // fifo of sampled mode/data pairs
  // ****************************************
  // rising-edge samples are queued; the controller drains one per cycle
  logic [1:0] q_data;
  logic       q_valid;
  logic       q_in_ready;
  logic       step;
  logic       tms;
  logic       tdi;

  stp_fifo #(
    .WIDTH (2),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_SYS_I),
    .rst_i       (SYS_RST_I),
    .in_data_i   ({tdi_s, tms_s}),
    .in_valid_i  (tck_rise),
    .in_ready_o  (q_in_ready),
    .out_data_o  (q_data),
    .out_valid_o (q_valid),
    .out_ready_i (1'b1)
  );

  // drain stalls are impossible; ready stays high, full never reached
  assign step = q_valid;
  assign tms  = q_data[0];
  assign tdi  = q_data[1];

  // ****************************************
  // controller
  // ****************************************
  stp_state_t state_reg;
  stp_state_t state_next;

  // standard next-state table
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET:  state_next = tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   state_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  state_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  state_next = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_next = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_next = tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  state_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  state_next = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_next = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_IDLE;
      default:   state_next = ST_RESET;
    endcase
  end

  // power-up lands in the reset state; memory logic is not in this block
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
      state_reg <= ST_RESET;
    else if (step)
      state_reg <= state_next;
  end

  // ****************************************
  // state strobes
  // ****************************************
  // each strobe marks one taken rising test-clock edge in that state; enter_tlr one whose next state is reset
  logic cap_ir;
  logic sh_ir;
  logic upd_ir;
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;
  logic enter_tlr;

  assign cap_ir    = step && (state_reg == ST_CAP_IR);
  assign sh_ir     = step && (state_reg == ST_SH_IR);
  assign upd_ir    = step && (state_reg == ST_UPD_IR);
  assign cap_dr    = step && (state_reg == ST_CAP_DR);
  assign sh_dr     = step && (state_reg == ST_SH_DR);
  assign upd_dr    = step && (state_reg == ST_UPD_DR);
  // reset-state side effects land on the edge that enters it, so the
  // identification instruction is active as soon as the state is shown
  assign enter_tlr = step && (state_next == ST_RESET);

  // ****************************************
  // instruction register
  // ****************************************
  logic [IR_W-1:0] ir_sh_reg;
  logic [IR_W-1:0] ir_reg;
  logic            sel_bypass;
  logic            sel_id;
  logic            sel_bsr;

  // shift stage: capture pattern, then msb-in shifting
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
      ir_sh_reg <= INS_IDCODE;
    else if (cap_ir)
      ir_sh_reg <= {1'b0, IR_CAPTURE};
    else if (sh_ir)
      ir_sh_reg <= {tdi, ir_sh_reg[IR_W-1:1]};
  end

  // active instruction changes only at update or reset
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
      ir_reg <= INS_IDCODE;
    else if (enter_tlr)
      ir_reg <= INS_IDCODE;
    else if (upd_ir)
      ir_reg <= ir_sh_reg;
  end

  // decode; anything unknown falls back to bypass
  assign sel_id     = (ir_reg == INS_IDCODE);
  assign sel_bsr    = (ir_reg == INS_EXTEST) || (ir_reg == INS_SAMPLE)
                   || (ir_reg == INS_SAMPLEZ);
  assign sel_bypass = !sel_id && !sel_bsr;

  // ****************************************
  // data registers
  // ****************************************
  logic             byp_reg;
  logic [ID_W-1:0]  id_reg;
  logic [BSR_W-1:0] bsr_reg;
  logic [BSR_W-1:0] bsr_upd_reg;

  // one bit bypass, captures zero
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
      byp_reg <= 1'b0;
    else if (cap_dr && sel_bypass)
      byp_reg <= 1'b0;
    else if (sh_dr && sel_bypass)
      byp_reg <= tdi;
  end

  // identification register
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
      id_reg <= '0;
    else if (cap_dr && sel_id)
      id_reg <= ID_VALUE;
    else if (sh_dr && sel_id)
      id_reg <= {tdi, id_reg[ID_W-1:1]};
  end

  // boundary chain over the sampled pins
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
      bsr_reg <= '0;
    else if (cap_dr && sel_bsr)
      bsr_reg <= pins_s2_reg;
    else if (sh_dr && sel_bsr)
      bsr_reg <= {tdi, bsr_reg[BSR_W-1:1]};
  end

  // preload latch, cleared in reset state
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
      bsr_upd_reg <= '0;
    else if (enter_tlr)
      bsr_upd_reg <= '0;
    else if (upd_dr && sel_bsr)
      bsr_upd_reg <= bsr_reg;
  end

  // ****************************************
  // serial output, falling edge
  // ****************************************
  logic tdo_mux;
  logic shifting;

  // exactly one source chosen; ir wins in the ir shift state
  always_comb
  begin
    tdo_mux = byp_reg;
    if (state_reg == ST_SH_IR)
      tdo_mux = ir_sh_reg[0];
    else if (sel_id)
      tdo_mux = id_reg[0];
    else if (sel_bsr)
      tdo_mux = bsr_reg[0];
  end

  // fifo runs ahead of the pin, so state is current at falling edge
  assign shifting = (state_reg == ST_SH_IR) || (state_reg == ST_SH_DR);

  // drive only on falling edges; disabled from reset
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      TDO_O    <= 1'b0;
      TDO_OE_O <= 1'b0;
    end
    else if (tck_fall)
    begin
      TDO_O    <= shifting ? tdo_mux : 1'b0;
      TDO_OE_O <= shifting;
    end
  end

  // registered status outputs
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      INSTR_O   <= INS_IDCODE;
      BSR_UPD_O <= '0;
      TLR_O     <= 1'b1;
    end
    else
    begin
      INSTR_O   <= ir_reg;
      BSR_UPD_O <= bsr_upd_reg;
      TLR_O     <= (state_reg == ST_RESET);
    end
  end

  logic unused_ready;
  assign unused_ready = q_in_ready;
endmodule : stp_tap

// *** logic/stp_pkg.sv ***
// stp_pkg: constants for the sram test access port block
// assumes a 100 MHz system clock that oversamples the test clock
package stp_pkg;
  // instruction register
  localparam int         IR_W        = 3;
  localparam logic [2:0] INS_EXTEST  = 3'h0;
  localparam logic [2:0] INS_IDCODE  = 3'h1;
  localparam logic [2:0] INS_SAMPLEZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE  = 3'h4;
  localparam logic [2:0] INS_BYPASS  = 3'h7;
  localparam logic [1:0] IR_CAPTURE  = 2'h1;
  localparam int         ID_W        = 32;
  localparam int         BSR_W       = 8;
  localparam int         RST_EDGES   = 5;
  localparam int         FIFO_DEPTH  = 16;

  typedef enum logic [15:0] {
    ST_RESET  = 16'h0001, ST_IDLE   = 16'h0002, ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008, ST_SH_DR  = 16'h0010, ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040, ST_EX2_DR = 16'h0080, ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PA_IR  = 16'h2000, ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } stp_state_t;
endpackage : stp_pkg

// *** logic/stp_fifo.sv ***
// stp_fifo: small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module stp_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,    // system clock
  input  wire logic             rst_i,    // sync reset
  input  wire logic [WIDTH-1:0] in_data_i,  // write data
  input  wire logic             in_valid_i, // write request
  output logic                  in_ready_o, // not full
  output logic [WIDTH-1:0]      out_data_o, // registered read data
  output logic                  out_valid_o,// not empty
  input  wire logic             out_ready_i // read accept
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;
  logic [AW-1:0]    rd_ptr_next;
  logic [WIDTH-1:0] out_data_reg;

  // handshakes on each side
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  assign out_data_o  = out_data_reg;

  // storage
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data_i;
  end

  // head word kept in a register; a push into the slot that becomes the
  // head is forwarded, since the array only holds it after this edge
  always_ff @(posedge clk_i)
  begin
    if (push && (wr_ptr_reg == rd_ptr_next))
      out_data_reg <= in_data_i;
    else
      out_data_reg <= mem_reg[rd_ptr_next];
  end

  // pointers and fill level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule : stp_fifo

// *** verification/stp_tap_monitor.sv ***
// stp_tap_monitor: concurrent checks on the test access port pins
// assumes it is bound to every stp_tap and sees only its ports
`timescale 1ns/1ps
module stp_tap_monitor
  import stp_pkg::*;
(
  input wire logic            CLK_SYS_I,     // system clock
  input wire logic            SYS_RST_I,     // sync reset
  input wire logic            TCK_I,         // test clock
  input wire logic            TMS_I,         // mode select
  input wire logic            TMS_PRESENT_I, // low when floating
  input wire logic            TDO_O,         // serial out
  input wire logic            TDO_OE_O,      // serial out enable
  input wire logic [IR_W-1:0] INSTR_O,       // active instruction
  input wire logic            TLR_O          // reset state
);
  logic       tck_reg; // test clock one cycle late
  logic [2:0] hi_reg;  // rises seen with mode high

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  // edge finder for the test clock
  always_ff @(posedge CLK_SYS_I)
  begin
    tck_reg <= TCK_I;
  end

  // run of high mode samples; a floating pin counts as high
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
      hi_reg <= 3'h0;
    else if (TCK_I && !tck_reg)
      hi_reg <= (TMS_I || !TMS_PRESENT_I) ? hi_reg + 3'h1 : 3'h0;
  end

  // ******************************
  // checks
  // ******************************
  chk_oe_in_tlr: assert property (TLR_O |-> !TDO_OE_O)
    else $error("serial out driven in reset state");
  chk_tlr_idcode: assert property (TLR_O [*3] |-> INSTR_O == INS_IDCODE)
    else $error("reset state without identification instruction");
  chk_after_reset: assert property ($past(SYS_RST_I) |-> TLR_O && !TDO_OE_O)
    else $error("port not reset after power-up");
  chk_tdo_on_fall: assert property ($changed(TDO_O) |-> !TCK_I && !$past(TCK_I, 2))
    else $error("serial out moved outside low phase");
  chk_oe_on_fall: assert property ($changed(TDO_OE_O) |-> !TCK_I && !$past(TCK_I, 2))
    else $error("enable moved outside low phase");
  chk_tlr_holds: assert property ($rose(TLR_O) |-> TLR_O [*8])
    else $error("reset state left too early");
  chk_oe_holds: assert property ($rose(TDO_OE_O) |-> TDO_OE_O [*8])
    else $error("enable pulse too short");
  chk_five_high: assert property (
    (TCK_I && !tck_reg && hi_reg == 3'h4 && (TMS_I || !TMS_PRESENT_I))
    |-> ##[1:12] TLR_O)
    else $error("five high mode edges did not reset");
  chk_ins_steady: assert property ($changed(INSTR_O) |-> !TDO_OE_O && !$past(TDO_OE_O))
    else $error("instruction changed while shifting");
endmodule : stp_tap_monitor

bind stp_tap stp_tap_monitor MON (
  .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .TCK_I(TCK_I), .TMS_I(TMS_I),
  .TMS_PRESENT_I(TMS_PRESENT_I), .TDO_O(TDO_O), .TDO_OE_O(TDO_OE_O),
  .INSTR_O(INSTR_O), .TLR_O(TLR_O)
);

// *** verification/stp_ctl_model.sv ***
// stp_ctl_model: board scan controller driving the test pins
// assumes the caller steps it from the system clock's falling edge
`timescale 1ns/1ps
module stp_ctl_model (
  input  wire logic clk_i,    // system clock, paces the test clock
  input  wire logic tdo_i,    // serial out of the port
  input  wire logic tdo_oe_i, // its enable
  output logic      tck_o,    // test clock, low between steps
  output logic      tms_o,    // mode select
  output logic      tdi_o     // serial data in
);
  // clock stands low when idle so the port never advances
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // one 160 ns test clock period; tdo read late in the low phase
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(negedge clk_i);
    tms_o = tms;
    tdi_o = tdi;
    repeat (7) @(negedge clk_i);
    tdo = tdo_oe_i ? tdo_i : 1'bz; // released pin reads as no value
    tck_o = 1'b1;
    repeat (8) @(negedge clk_i);
    tck_o = 1'b0;
  endtask : step
endmodule : stp_ctl_model

// *** verification/stp_tap_bench.sv ***
// stp_tap_bench: self-checking bench for the test access port
// assumes stp_ctl_model as the far side and the bound monitor
`timescale 1ns/1ps
module stp_tap_bench
  import stp_pkg::*;
;
  localparam logic [31:0] ID_VAL = 32'h1357_9BDF; // arbitrary value
  logic             clk, rst, tck, tms, tdi, tms_pres, tdi_pres;
  logic [BSR_W-1:0] pins, bsr;
  logic             tdo, oe, tlr, t;
  logic [IR_W-1:0]  instr;
  logic [15:0]      lfsr_reg;
  logic [39:0]      d, q;
  logic [2:0]       codes [5];
  int               n_fail, n_checks;

  stp_tap #(.ID_VALUE(ID_VAL)) DUT (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .TCK_I(tck), .TMS_I(tms),
    .TMS_PRESENT_I(tms_pres), .TDI_I(tdi), .TDI_PRESENT_I(tdi_pres), .PINS_I(pins),
    .TDO_O(tdo), .TDO_OE_O(oe), .INSTR_O(instr), .BSR_UPD_O(bsr), .TLR_O(tlr)
  );
  stp_ctl_model ctl (
    .clk_i(clk), .tdo_i(tdo), .tdo_oe_i(oe), .tck_o(tck), .tms_o(tms), .tdi_o(tdi)
  );

  // ******************************
  // helpers
  // ******************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction : lfsr

  // capture value and length of the selected chain, then delayed tdi
  function automatic logic [39:0] exp_dr(input logic [2:0] c, input logic [7:0] p,
                                         input logic [39:0] din);
    int          l;
    logic [39:0] cap;
    l = 1;
    cap = 40'h0; // bypass captures zero
    if (c == INS_IDCODE)
    begin
      l = ID_W;
      cap = 40'(ID_VAL);
    end
    if (c == INS_EXTEST || c == INS_SAMPLE || c == INS_SAMPLEZ)
    begin
      l = BSR_W;
      cap = 40'(p);
    end
    exp_dr = (din << l) | (cap & ((40'h1 << l) - 40'h1));
  endfunction : exp_dr

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // idle -> capture -> shift n bits lsb first -> update -> idle
  task automatic scan(input logic ir, input int n, input logic [39:0] din,
                      output logic [39:0] dout);
    logic [2:0] held;
    held = instr;
    dout = 40'h0;
    ctl.step(1'b1, 1'b0, t);
    if (ir)
      ctl.step(1'b1, 1'b0, t);
    ctl.step(1'b0, 1'b0, t);
    ctl.step(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++)
    begin
      ctl.step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    if (ir)
      chk("instr before update", 40'(held), 40'(instr));
    ctl.step(1'b1, 1'b0, t);
    ctl.step(1'b0, 1'b0, t);
  endtask : scan

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, far beyond the roughly 50 microseconds the tests need
  initial
  begin
    #900000;
    n_fail++;
    $display("[FAIL] watchdog expired");
    report_and_stop();
  end

  // ******************************
  // tests
  // ******************************
  initial
  begin
    rst = 1'b1;
    tms_pres = 1'b1;
    tdi_pres = 1'b1;
    pins = 8'h00;
    lfsr_reg = 16'h7FC6;
    codes = '{INS_EXTEST, INS_IDCODE, INS_SAMPLEZ, INS_SAMPLE, INS_BYPASS};
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("tlr", 40'h1, 40'(tlr));
    chk("oe", 40'h0, 40'(oe));
    chk("instr", 40'(INS_IDCODE), 40'(instr));
    ctl.step(1'b0, 1'b0, t);
    scan(1'b1, 3, 40'(INS_IDCODE), q);
    chk("ir capture", 40'h1, q);
    $display("test power-up done");
    // every legal code, random data and pins
    for (int c = 0; c < 5; c++)
    begin
      lfsr_reg = lfsr(lfsr_reg);
      pins = lfsr_reg[15:8];
      scan(1'b1, 3, 40'(codes[c]), q);
      chk("instr", 40'(codes[c]), 40'(instr));
      d = {lfsr_reg[7:0], lfsr_reg, lfsr(lfsr_reg)};
      scan(1'b0, 40, d, q);
      chk("dr chain", exp_dr(codes[c], pins, d), q);
      if (codes[c] == INS_EXTEST || codes[c] == INS_SAMPLE)
        chk("preload", 40'(d[39:32]), 40'(bsr));
      chk("oe idle", 40'h0, 40'(oe));
      $display("test code %0d done", codes[c]);
    end
    // five floating mode edges from inside a shift
    ctl.step(1'b1, 1'b0, t);
    ctl.step(1'b0, 1'b0, t);
    ctl.step(1'b0, 1'b0, t);
    tms_pres = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      chk("tlr early", 40'h0, 40'(tlr));
      ctl.step(1'b0, 1'b0, t);
    end
    chk("tlr", 40'h1, 40'(tlr));
    chk("instr", 40'(INS_IDCODE), 40'(instr));
    tms_pres = 1'b1;
    ctl.step(1'b0, 1'b0, t);
    $display("test forced reset done");
    // floating data pin shifts ones: bypass loads, then 0 and ones
    tdi_pres = 1'b0;
    scan(1'b1, 3, 40'h0, q);
    chk("instr", 40'(INS_BYPASS), 40'(instr));
    scan(1'b0, 4, 40'h0, q);
    chk("bypass", 40'h0E, q);
    tdi_pres = 1'b1;
    $display("test floating data done");
    // system reset in mid-run
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("tlr", 40'h1, 40'(tlr));
    chk("instr", 40'(INS_IDCODE), 40'(instr));
    $display("test second reset done");
    report_and_stop();
  end
endmodule : stp_tap_bench
